// ===== src/gpos_pin7_out.sv
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps

// Operation
// RULE_01: source field bits 4:2: rx ports 0-3, status, 101 reserved, tx 0/1.
// RULE_02: select field bits 7:5 picks the signal; meaning depends on source.
// RULE_03: rx source, select 000-011 forwards remote pins 0 to 3.
// RULE_04: rx source, select 100 drives that port's lock indication.
// RULE_05: rx source, select 101 drives that port's pass indication.
// RULE_06: rx source, select 110 frame valid, 111 line valid.
// RULE_07: status source, one select code drives OR of enabled ports' lock.
// RULE_08: status source, select 010 drives AND of enabled ports' lock.
// RULE_09: status source, select 011 drives AND of enabled ports' pass.
// RULE_10: tx source, 000 AND and 001 OR of selected rx ports' pass.
// RULE_11: tx source, one code flags frame being sent, 011 line being sent.
// RULE_12: tx source, select 100 flags multi-port data synchronised.
// RULE_13: tx source, 101 drives port interrupt; 111 reserved.
// RULE_14: pin driven only when bit 0 set; bit 1 is local level.
// RULE_15: after reset all fields zero, driver disabled.
// RULE_16: reserved source or select codes drive low when enabled.
// RULE_17: control fields live in one 8-bit register resetting to zero.
module gpos_pin7_out
    import gpos_pkg::*;
(
    input  wire logic                        clock,
    input  wire logic                        reset,
    input  wire logic                        clock_enable,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [gpos_pkg::GPOS_ADDR_W-1:0] paddr,
    input  wire logic [gpos_pkg::GPOS_DATA_W-1:0] pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [gpos_pkg::GPOS_DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire gpos_pkg::gpos_rx_s [3:0]    rx_port,
    input  wire logic [3:0]                  rx_port_enable,
    input  wire gpos_pkg::gpos_tx_s [1:0]    tx_port,
    input  wire logic [1:0][3:0]             tx_rx_select,
    input  wire logic                        frame_sync_pulse,
    output logic                             pin7_out,
    output logic                             pin7_oe_n
);

    import gpos_pkg::*;

    gpos_ctrl_s       pin7_output_control;
    logic             ctrl_write;
    logic [7:0]       ctrl_wdata;
    logic [7:0]       stat_rdata;
    logic [31:0]      rx_flat;
    logic [7:0]       tx_flat;
    gpos_rx_s [3:0]   rx_sync;
    gpos_tx_s [1:0]   tx_sync;

    logic [2:0]       pin7_signal_select;
    logic [2:0]       pin7_source_select;
    logic             pin7_local_level;
    logic             pin7_drive_enable;

    logic [3:0]       rx_level;
    logic [1:0]       tx_level;
    logic [3:0]       lock_vec;
    logic [3:0]       pass_vec;
    logic             lock_or;
    logic             lock_and;
    logic             pass_and;
    logic             dev_level;
    logic             src_level;
    logic             next_pin7_out;
    logic             next_pin7_oe_n;

    // receive port signal picked by the select code
    function automatic logic rx_pick(input gpos_rx_s p,
                                     input logic [2:0] sel);
        logic v;
        v = 1'b0;
        if (sel[2] == 1'b0)
            v = p.remote_gpio[sel[1:0]];               // [RULE_03]
        else if (sel == GPOS_RX_LOCK)
            v = p.lock;                                // [RULE_04]
        else if (sel == GPOS_RX_PASS)
            v = p.pass;                                // [RULE_05]
        else if (sel == GPOS_RX_FRAME)
            v = p.frame_valid;                         // [RULE_06]
        else
            v = p.line_valid;                          // [RULE_06]
        return v;
    endfunction : rx_pick

    // and/or over a port mask; an empty mask gives low
    function automatic logic mask_and(input logic [3:0] v,
                                      input logic [3:0] m);
        return (|m) & (&(v | ~m));
    endfunction : mask_and

    function automatic logic mask_or(input logic [3:0] v,
                                     input logic [3:0] m);
        return |(v & m);
    endfunction : mask_or

    // transmit port signal picked by the select code
    function automatic logic tx_pick(input gpos_tx_s t,
                                     input logic [3:0] rx_sel,
                                     input logic [3:0] pass,
                                     input logic [2:0] sel);
        logic v;
        v = 1'b0;
        if (sel == GPOS_TX_PASS_AND)
            v = mask_and(pass, rx_sel);                // [RULE_10]
        else if (sel == GPOS_TX_PASS_OR)
            v = mask_or(pass, rx_sel);                 // [RULE_10]
        else if (sel == GPOS_TX_FRAME)
            v = t.frame_active;                        // [RULE_11]
        else if (sel == GPOS_TX_LINE)
            v = t.line_active;                         // [RULE_11]
        else if (sel == GPOS_TX_SYNCED)
            v = t.synced;                              // [RULE_12]
        else if (sel == GPOS_TX_IRQ)
            v = t.interrupt;                           // [RULE_13]
        else
            v = 1'b0;                                  // [RULE_13] [RULE_16]
        return v;
    endfunction : tx_pick

    gpos_apb u_apb (
        .clock        (clock),
        .reset        (reset),
        .clock_enable (clock_enable),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .pstrb        (pstrb),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .ctrl_rdata   (pin7_output_control),
        .stat_rdata   (stat_rdata),
        .ctrl_write   (ctrl_write),
        .ctrl_wdata   (ctrl_wdata)
    );

    // port status arrives from other clock domains
    assign rx_flat = rx_port;
    assign tx_flat = tx_port;

    gpos_sync #(.WIDTH(32)) u_rx_sync (
        .clock        (clock),
        .reset        (reset),
        .clock_enable (clock_enable),
        .async_in     (rx_flat),
        .sync_out     (rx_sync)
    );

    gpos_sync #(.WIDTH(8)) u_tx_sync (
        .clock        (clock),
        .reset        (reset),
        .clock_enable (clock_enable),
        .async_in     (tx_flat),
        .sync_out     (tx_sync)
    );

    // control register
    always_ff @(posedge clock) begin
        if (reset) begin
            pin7_output_control <= GPOS_CTRL_RESET;    // [RULE_15] [RULE_17]
        end else if (clock_enable && ctrl_write) begin
            pin7_output_control <= ctrl_wdata;         // [RULE_17]
        end
    end

    assign pin7_signal_select = pin7_output_control[GPOS_SEL_LSB +: 3];
    assign pin7_source_select = pin7_output_control[GPOS_SRC_LSB +: 3];
    assign pin7_local_level   = pin7_output_control[GPOS_LVL_BIT];
    assign pin7_drive_enable  = pin7_output_control[GPOS_EN_BIT];

    assign stat_rdata = {6'h00, ~pin7_oe_n, pin7_out};

    genvar gp;
    generate
        for (gp = 0; gp < GPOS_RX_PORTS; gp++) begin : g_rx
            assign rx_level[gp] = rx_pick(rx_sync[gp],
                                          pin7_signal_select); // [RULE_02]
            assign lock_vec[gp] = rx_sync[gp].lock;
            assign pass_vec[gp] = rx_sync[gp].pass;
        end
        for (gp = 0; gp < GPOS_TX_PORTS; gp++) begin : g_tx
            assign tx_level[gp] = tx_pick(tx_sync[gp], tx_rx_select[gp],
                                          pass_vec,
                                          pin7_signal_select); // [RULE_02]
        end
    endgenerate

    // device-wide status group
    assign lock_or  = mask_or(lock_vec, rx_port_enable);   // [RULE_07]
    assign lock_and = mask_and(lock_vec, rx_port_enable);  // [RULE_08]
    assign pass_and = mask_and(pass_vec, rx_port_enable);  // [RULE_09]

    assign dev_level =
        (pin7_signal_select == GPOS_DEV_LOCAL) ? pin7_local_level : // [RULE_14]
        (pin7_signal_select == GPOS_DEV_LOCK_OR) ? lock_or :        // [RULE_07]
        (pin7_signal_select == GPOS_DEV_LOCK_AND) ? lock_and :      // [RULE_08]
        (pin7_signal_select == GPOS_DEV_PASS_AND) ? pass_and :      // [RULE_09]
        (pin7_signal_select == GPOS_DEV_FSYNC) ? frame_sync_pulse :
                                                 1'b0;              // [RULE_16]

    // source decode
    assign src_level =
        (pin7_source_select <= GPOS_SRC_RX3) ?
            rx_level[pin7_source_select[1:0]] :        // [RULE_01]
        (pin7_source_select == GPOS_SRC_DEV) ? dev_level :  // [RULE_01]
        (pin7_source_select == GPOS_SRC_TX0) ? tx_level[0] : // [RULE_01]
        (pin7_source_select == GPOS_SRC_TX1) ? tx_level[1] : // [RULE_01]
                                               1'b0;   // [RULE_16]

    assign next_pin7_out  = pin7_drive_enable & src_level;   // [RULE_14]
    assign next_pin7_oe_n = ~pin7_drive_enable;              // [RULE_14]

    // pin drive flops
    always_ff @(posedge clock) begin
        if (reset) begin
            pin7_out  <= 1'b0;
            pin7_oe_n <= 1'b1;                         // [RULE_15]
        end else if (clock_enable) begin
            pin7_out  <= next_pin7_out;
            pin7_oe_n <= next_pin7_oe_n;
        end
    end

endmodule : gpos_pin7_out

// ===== src/gpos_pkg.sv
package gpos_pkg;

    localparam int GPOS_RX_PORTS = 4;
    localparam int GPOS_TX_PORTS = 2;
    localparam int GPOS_ADDR_W   = 10;
    localparam int GPOS_DATA_W   = 32;

    // register indices; byte address is index times four
    localparam logic [7:0] GPOS_CTRL_INDEX = 8'h17;
    localparam logic [7:0] GPOS_STAT_INDEX = 8'h40;
    localparam logic [7:0] GPOS_CTRL_RESET = 8'h00;

    // control field positions
    localparam int GPOS_EN_BIT  = 0;
    localparam int GPOS_LVL_BIT = 1;
    localparam int GPOS_SRC_LSB = 2;
    localparam int GPOS_SEL_LSB = 5;

    // source codes
    localparam logic [2:0] GPOS_SRC_RX0  = 3'h0;
    localparam logic [2:0] GPOS_SRC_RX3  = 3'h3;
    localparam logic [2:0] GPOS_SRC_DEV  = 3'h4;
    localparam logic [2:0] GPOS_SRC_RSVD = 3'h5;
    localparam logic [2:0] GPOS_SRC_TX0  = 3'h6;
    localparam logic [2:0] GPOS_SRC_TX1  = 3'h7;

    // receive port select codes (0xx forward remote pin xx)
    localparam logic [2:0] GPOS_RX_LOCK  = 3'h4;
    localparam logic [2:0] GPOS_RX_PASS  = 3'h5;
    localparam logic [2:0] GPOS_RX_FRAME = 3'h6;
    localparam logic [2:0] GPOS_RX_LINE  = 3'h7;

    // device status select codes
    localparam logic [2:0] GPOS_DEV_LOCAL    = 3'h0;
    localparam logic [2:0] GPOS_DEV_LOCK_OR  = 3'h1;
    localparam logic [2:0] GPOS_DEV_LOCK_AND = 3'h2;
    localparam logic [2:0] GPOS_DEV_PASS_AND = 3'h3;
    localparam logic [2:0] GPOS_DEV_FSYNC    = 3'h4;

    // transmit port select codes
    localparam logic [2:0] GPOS_TX_PASS_AND = 3'h0;
    localparam logic [2:0] GPOS_TX_PASS_OR  = 3'h1;
    localparam logic [2:0] GPOS_TX_FRAME    = 3'h2;
    localparam logic [2:0] GPOS_TX_LINE     = 3'h3;
    localparam logic [2:0] GPOS_TX_SYNCED   = 3'h4;
    localparam logic [2:0] GPOS_TX_IRQ      = 3'h5;

    typedef struct packed {
        logic [2:0] sel;
        logic [2:0] src;
        logic       level;
        logic       enable;
    } gpos_ctrl_s;

    typedef struct packed {
        logic [3:0] remote_gpio;
        logic       lock;
        logic       pass;
        logic       frame_valid;
        logic       line_valid;
    } gpos_rx_s;

    typedef struct packed {
        logic frame_active;
        logic line_active;
        logic synced;
        logic interrupt;
    } gpos_tx_s;

endpackage : gpos_pkg

// ===== src/gpos_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser for a vector of independent levels
module gpos_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             clock_enable,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock) begin
        if (reset) begin
            stage1   <= '0;
            sync_out <= '0;
        end else if (clock_enable) begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : gpos_sync

// ===== src/gpos_apb.sv
`timescale 1ns/1ps

// apb slave: one wait-free access, registered answer
module gpos_apb
    import gpos_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   reset,
    input  wire logic                   clock_enable,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [GPOS_ADDR_W-1:0] paddr,
    input  wire logic [GPOS_DATA_W-1:0] pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [GPOS_DATA_W-1:0] prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [7:0]             ctrl_rdata,
    input  wire logic [7:0]             stat_rdata,
    output logic                        ctrl_write,
    output logic      [7:0]             ctrl_wdata
);

    function automatic logic addr_hit(input logic [GPOS_ADDR_W-1:0] a,
                                      input logic [7:0] index);
        return a == {index, 2'b00};
    endfunction : addr_hit

    logic                   setup;
    logic                   done;
    logic                   hit_ctrl;
    logic                   hit_stat;
    logic                   next_err;
    logic [GPOS_DATA_W-1:0] next_rdata;

    assign setup    = psel & ~penable;
    assign done     = psel & penable & pready;
    assign hit_ctrl = addr_hit(paddr, GPOS_CTRL_INDEX);
    assign hit_stat = addr_hit(paddr, GPOS_STAT_INDEX);
    // unmapped address, or a write to the read-only status word
    assign next_err = ~(hit_ctrl | hit_stat) | (pwrite & hit_stat);
    assign next_rdata = (pwrite | next_err) ? '0 :
                        hit_ctrl ? {24'h000000, ctrl_rdata} :
                                   {24'h000000, stat_rdata};

    assign ctrl_write = done & pwrite & hit_ctrl & pstrb[0];
    assign ctrl_wdata = pwdata[7:0];

    always_ff @(posedge clock) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (clock_enable) begin
            pready <= setup;
            if (setup) begin
                pslverr <= next_err;
                prdata  <= next_rdata;
            end
        end
    end

endmodule : gpos_apb

// ===== verification/gpos_pin7_out_sva.sv
`timescale 1ns/1ps

module gpos_pin7_out_sva
    import gpos_pkg::*;
(
    input wire logic                               clock,
    input wire logic                               reset,
    input wire logic                               clock_enable,
    input wire logic                               psel,
    input wire logic                               penable,
    input wire logic                               pwrite,
    input wire logic [gpos_pkg::GPOS_ADDR_W-1:0]   paddr,
    input wire logic [gpos_pkg::GPOS_DATA_W-1:0]   pwdata,
    input wire logic [3:0]                         pstrb,
    input wire logic [gpos_pkg::GPOS_DATA_W-1:0]   prdata,
    input wire logic                               pready,
    input wire logic                               pslverr,
    input wire logic                               pin7_out,
    input wire logic                               pin7_oe_n
);
    localparam logic [9:0] CA = {GPOS_CTRL_INDEX, 2'b00};
    localparam logic [9:0] SA = {GPOS_STAT_INDEX, 2'b00};
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire        req = psel && !penable && clock_enable;
    wire        cw  = psel && penable && pready && pwrite && clock_enable
                      && paddr == CA && pstrb[0];
    logic [7:0] shadow;
    // expected control contents, tracked from completed writes
    always_ff @(posedge clock) begin
        if (reset)
            shadow <= 8'h00;
        else if (cw)
            shadow <= pwdata[7:0];
    end
    idle_low_a: assert property (pin7_oe_n |-> !pin7_out)
        else $error("pin high while driver off");
    reset_quiet_a: assert property (
        $fell(reset) |-> pin7_oe_n && !pready)
        else $error("outputs not quiet after reset");
    ready_once_a: assert property (req |=> pready ##1 !pready)
        else $error("ready not a single cycle");
    bad_addr_a: assert property (
        req && paddr != CA && paddr != SA |=> pslverr && prdata == 32'h0)
        else $error("unmapped access accepted");
    ro_status_a: assert property (
        req && pwrite && paddr == SA |=> pslverr)
        else $error("status write accepted");
    readback_a: assert property (
        pready && !pwrite && paddr == CA |->
        prdata == {24'h0, shadow} && !pslverr)
        else $error("control readback");
    status_a: assert property (
        pready && !pwrite && paddr == SA |->
        prdata == {30'h0, ~$past(pin7_oe_n), $past(pin7_out)})
        else $error("status does not mirror pin");
    enable_a: assert property (
        cw |-> ##2 pin7_oe_n == !$past(pwdata[0], 2))
        else $error("enable not applied");
    level_a: assert property (
        cw && pwdata[7:0] ==? 8'b000100?1 |->
        ##2 pin7_out == $past(pwdata[1], 2))
        else $error("local level wrong");
    rsvd_low_a: assert property (
        cw && pwdata[4:2] == 3'b101 |-> ##2 !pin7_out)
        else $error("reserved source not low");
endmodule : gpos_pin7_out_sva

bind gpos_pin7_out gpos_pin7_out_sva u_sva (.clock, .reset, .clock_enable,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .pin7_out, .pin7_oe_n);

// ===== verification/gpos_pin_load.sv
`timescale 1ns/1ps

// board load on the pin: weak pull-down wins while the driver is off
module gpos_pin_load (
    input  wire logic pin7_out,
    input  wire logic pin7_oe_n,
    output logic      pin_level
);
    assign pin_level = pin7_oe_n ? 1'b0 : pin7_out;
endmodule : gpos_pin_load

// ===== verification/gpos_pin7_out_tb.sv
`timescale 1ns/1ps

module gpos_pin7_out_tb;
    import gpos_pkg::*;
    localparam logic [9:0] CA = {GPOS_CTRL_INDEX, 2'b00};
    localparam logic [9:0] SA = {GPOS_STAT_INDEX, 2'b00};
    logic            clock = 1'b0;
    logic            reset = 1'b1;
    logic            clock_enable = 1'b1;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [9:0]      paddr = 10'h000;
    logic [31:0]     pwdata = 32'h0;
    logic [3:0]      pstrb = 4'h0;
    logic [31:0]     prdata, rdata;
    logic            pready, pslverr, rerr, pin7_out, pin7_oe_n, pin_level;
    gpos_rx_s [3:0]  rx_port = '0;
    gpos_rx_s [3:0]  v;
    logic [3:0]      rx_port_enable = 4'h0;
    gpos_tx_s [1:0]  tx_port = '0;
    logic [1:0][3:0] tx_rx_select = '0;
    logic            frame_sync_pulse = 1'b0;
    logic [11:0]     dv [3] = '{12'h535, 12'h57F, 12'h0FF};
    logic [3:0]      en, lk, ps, tp;
    logic [7:0]      pat;
    logic            e;
    int              fails = 0;
    int              n_tests = 0;

    gpos_pin7_out dut (.clock, .reset, .clock_enable, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .rx_port, .rx_port_enable, .tx_port, .tx_rx_select,
        .frame_sync_pulse, .pin7_out, .pin7_oe_n);
    gpos_pin_load load (.pin7_out, .pin7_oe_n, .pin_level);

    initial forever #25 clock = ~clock;

    task automatic summarize;
        $display("compares %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; answer taken at the edge where pready is high
    task automatic apb(input logic w, input logic [9:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= s;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // only the watchdog ends a wait that never sees ready
        while (pready !== 1'b1) @(posedge clock);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // program the control byte, then look at the pin and the status
    task automatic pin(input logic [7:0] c, input logic x);
        apb(1'b1, CA, {24'h0, c}, 4'h1);
        repeat (5) @(negedge clock);
        check({31'h0, pin_level}, {31'h0, x});
        check({31'h0, pin7_oe_n}, {31'h0, ~c[0]});
        apb(1'b0, SA, 32'h0, 4'hF);
        check(rdata, {30'h0, c[0], x});
    endtask : pin

    initial begin
        repeat (30000) @(posedge clock);
        fails++;
        summarize();
    end

    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        check({31'h0, pin7_oe_n}, 32'h1);
        apb(1'b0, CA, 32'h0, 4'hF);
        check(rdata, 32'h0);
        $display("test reset end");
        apb(1'b1, CA, 32'hFF, 4'h1);
        apb(1'b1, CA, 32'h00, 4'h0);
        apb(1'b0, CA, 32'h0, 4'hF);
        check(rdata, 32'hFF);
        apb(1'b0, 10'h3FC, 32'h0, 4'hF);
        check({rerr, rdata[30:0]}, 32'h80000000);
        apb(1'b1, SA, 32'h0, 4'h1);
        check({31'h0, rerr}, 32'h1);
        $display("test registers end");
        pin(8'h13, 1'b1);
        pin(8'h11, 1'b0);
        pin(8'h12, 1'b0);
        $display("test local end");
        for (int k = 0; k < 64; k++) begin
            pat = k[3] ? 8'hA5 : 8'h5A;
            v = {4{~pat}};
            v[k[5:4]] = pat;
            @(posedge clock);
            rx_port <= v;
            e = k[2] ? pat[7 - k[2:0]] : pat[4 + k[1:0]];
            pin({k[2:0], 1'b0, k[5:4], 2'b01}, e);
        end
        $display("test receive end");
        for (int c = 0; c < 3; c++) begin
            {en, lk, ps} = dv[c];
            v = '0;
            for (int i = 0; i < 4; i++) begin
                v[i].lock = lk[i];
                v[i].pass = ps[i];
            end
            @(posedge clock);
            rx_port          <= v;
            rx_port_enable   <= en;
            frame_sync_pulse <= c[0];
            for (int s = 1; s < 8; s++) begin
                case (s)
                    1: e = |(lk & en);
                    2: e = en != 0 && (lk & en) == en;
                    3: e = en != 0 && (ps & en) == en;
                    4: e = c[0];
                    default: e = 1'b0;
                endcase
                pin({s[2:0], 5'b10001}, e);
            end
        end
        $display("test status end");
        @(posedge clock);
        rx_port      <= {8'h00, 8'h00, 8'h04, 8'h04};
        tx_rx_select <= {4'b0110, 4'b0011};
        for (int k = 0; k < 32; k++) begin
            tp = k[3] ? 4'hA : 4'h5;
            @(posedge clock);
            tx_port <= k[4] ? {tp, ~tp} : {~tp, tp};
            case (k[2:0])
                0: e = !k[4];
                1: e = 1'b1;
                6, 7: e = 1'b0;
                default: e = tp[5 - k[2:0]];
            endcase
            pin({k[2:0], 2'b11, k[4], 2'b01}, e);
        end
        $display("test transmit end");
        @(posedge clock);
        rx_port          <= '1;
        tx_port          <= '1;
        rx_port_enable   <= 4'hF;
        frame_sync_pulse <= 1'b1;
        for (int s = 0; s < 8; s++) pin({s[2:0], 5'b10101}, 1'b0);
        $display("test reserved end");
        pin(8'h93, 1'b1);
        // clock enable low must hold the pin although its source drops
        @(posedge clock);
        clock_enable     <= 1'b0;
        frame_sync_pulse <= 1'b0;
        repeat (5) @(negedge clock);
        check({31'h0, pin_level}, 32'h1);
        @(posedge clock);
        clock_enable <= 1'b1;
        repeat (3) @(negedge clock);
        check({31'h0, pin_level}, 32'h0);
        $display("test freeze end");
        pin(8'h13, 1'b1);
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        check({31'h0, pin7_oe_n}, 32'h1);
        apb(1'b0, CA, 32'h0, 4'hF);
        check(rdata, 32'h0);
        $display("test second reset end");
        summarize();
    end
endmodule : gpos_pin7_out_tb
